// file: logic/mps_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module mps_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,    // System clock.
  input wire logic i_rst_n,      // Asynchronous reset, active low.
  mps_strm_if.cons s_in,         // Filling side.
  mps_strm_if.prod s_out         // Draining side.
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Full is told apart from empty by the extra pointer bit.
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign push = s_in.valid && !full;
  assign pop = s_out.ready && !empty;

  assign s_in.ready = !full;
  assign s_out.valid = !empty;
  assign s_out.data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= s_in.data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

// file: logic/mps_pkg.sv
// Constants shared by the serial slave port of the motor pre-driver.
// Assumes a single 20 MHz system clock and a 16-bit framed serial link.
package mps_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_OVER = 5'h11;
  localparam int RW_MSB = 15;
  localparam int RW_LSB = 14;
  localparam int ADDR_MSB = 13;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam logic [1:0] RW_WRITE = 2'h1;
  localparam logic [1:0] RW_READ = 2'h0;

  // Outgoing word: bit 15 zero, bit 14 fault, bits 13..9 zero, bit 8 one.
  localparam int TX_FAULT_POS = 14;
  localparam int TX_MARK_POS = 8;

  // ****************************************************************
  // Write queue
  // ****************************************************************
  localparam int WR_WIDTH = 14;
  localparam int WR_DEPTH = 16;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [5:0] RST_RD_ADDR = 6'h00;
  localparam logic RST_FAULT = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_WAIT_NS = 5000;
  localparam int WAIT_CYC = (T_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 7;
  localparam logic [6:0] WAIT_CNT = 7'(WAIT_CYC);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FRAME,
    ST_CLOSE
  } mps_state_e;

endpackage

// file: logic/mps_spi_slave.sv
// Serial slave port of a three-phase motor pre-driver.
// Assumes the master drives chip select, serial clock and data in,
// all asynchronous to i_ref_clk and far slower than it.
`timescale 1ns/1ps
module mps_spi_slave (
  input wire logic i_ref_clk,           // System clock, 20 MHz.
  input wire logic i_rst_n,             // Asynchronous reset, active low.
  input wire logic i_cs_n,              // Chip select from master, active low.
  input wire logic i_sck,               // Serial clock from master.
  input wire logic i_din,               // Serial data from master.
  output logic o_dout,                  // Serial data to master.
  output logic o_dout_oe_n,             // Low while o_dout drives the pin.
  output logic [5:0] o_rd_addr,         // Address of the last good read frame.
  input wire logic [7:0] i_rd_data,     // Register contents at o_rd_addr.
  output logic o_wr_valid,              // A queued register write is offered.
  input wire logic i_wr_ready,          // Core takes the offered write.
  output logic [5:0] o_wr_addr,         // Address of the offered write.
  output logic [7:0] o_wr_data,         // Data of the offered write.
  output logic o_frame_fault,           // Last frame was erroneous.
  output logic o_gap_short              // Pulse: select fell too soon.
);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  // The first stage of each pair is read only by the second stage.
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic sck_s1;
  logic sck_s2;
  logic sck_d;
  logic din_s1;
  logic din_s2;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      cs_s1 <= i_cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
    end else begin
      sck_s1 <= i_sck;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      din_s1 <= i_din;
      din_s2 <= din_s1;
    end
  end

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  // Data in has the same two-stage delay as the clock edge it is read on,
  // so the sampled bit is the one present before the master's next change.
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  assign cs_fall = cs_d && !cs_s2;
  assign cs_rise = !cs_d && cs_s2;
  assign sck_rise = !sck_d && sck_s2;
  assign sck_fall = sck_d && !sck_s2;

  // ****************************************************************
  // Frame sequencing
  // ****************************************************************
  // The port never makes a clock or select of its own; it only follows
  // the edges the master produces.
  mps_pkg::mps_state_e state;
  mps_pkg::mps_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      mps_pkg::ST_IDLE: begin
        if (cs_fall) begin
          next_state = mps_pkg::ST_FRAME;
        end
      end
      mps_pkg::ST_FRAME: begin
        if (cs_rise) begin
          next_state = mps_pkg::ST_CLOSE;
        end
      end
      mps_pkg::ST_CLOSE: begin
        next_state = mps_pkg::ST_IDLE;
      end
      default: begin
        next_state = mps_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= mps_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  logic in_frame;
  assign in_frame = (state == mps_pkg::ST_FRAME);

  // ****************************************************************
  // Receive path
  // ****************************************************************
  // Clock edges outside a frame never reach the shifter or counter.
  logic [mps_pkg::FRAME_BITS-1:0] rx_shift;
  logic [mps_pkg::CNT_W-1:0] pulse_cnt;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_shift <= '0;
    end else if (in_frame && sck_rise) begin
      rx_shift <= {rx_shift[mps_pkg::FRAME_BITS-2:0], din_s2};
    end
  end

  // The count saturates one above sixteen so that long frames stay wrong.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_cnt <= '0;
    end else if (state == mps_pkg::ST_IDLE && cs_fall) begin
      pulse_cnt <= '0;
    end else if (in_frame && sck_rise && pulse_cnt != mps_pkg::CNT_OVER) begin
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end

  // ****************************************************************
  // Frame evaluation
  // ****************************************************************
  logic [1:0] rx_rw;
  logic [5:0] rx_addr;
  logic [7:0] rx_data;
  logic count_ok;
  logic is_write;
  logic is_read;
  logic wr_blocked;
  logic frame_good;

  assign rx_rw = rx_shift[mps_pkg::RW_MSB:mps_pkg::RW_LSB];
  assign rx_addr = rx_shift[mps_pkg::ADDR_MSB:mps_pkg::ADDR_LSB];
  assign rx_data = rx_shift[mps_pkg::DATA_MSB:mps_pkg::DATA_LSB];
  assign count_ok = (pulse_cnt == mps_pkg::CNT_FULL);
  assign is_write = (rx_rw == mps_pkg::RW_WRITE);
  assign is_read = (rx_rw == mps_pkg::RW_READ);

  mps_strm_if #(.WIDTH(mps_pkg::WR_WIDTH)) fill_if ();
  mps_strm_if #(.WIDTH(mps_pkg::WR_WIDTH)) drain_if ();

  // A write that finds the queue full cannot be held off on the link, so
  // it is dropped and reported like any other erroneous frame.
  assign wr_blocked = is_write && !fill_if.ready;
  assign frame_good = count_ok && !wr_blocked;

  assign fill_if.valid = (state == mps_pkg::ST_CLOSE) && count_ok && is_write;
  assign fill_if.data = {rx_addr, rx_data};

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_addr <= mps_pkg::RST_RD_ADDR;
    end else if (state == mps_pkg::ST_CLOSE && count_ok && is_read) begin
      o_rd_addr <= rx_addr;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_frame_fault <= mps_pkg::RST_FAULT;
    end else if (state == mps_pkg::ST_CLOSE) begin
      o_frame_fault <= !frame_good;
    end
  end

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  // The word is fixed at select fall from the read address of the last
  // good read frame; a write can change only the fault bit of the word.
  logic [mps_pkg::FRAME_BITS-1:0] tx_word;
  logic [mps_pkg::FRAME_BITS-1:0] tx_shift;

  always_comb begin
    tx_word = '0;
    tx_word[mps_pkg::TX_FAULT_POS] = o_frame_fault;
    tx_word[mps_pkg::TX_MARK_POS] = 1'b1;
    tx_word[mps_pkg::DATA_MSB:mps_pkg::DATA_LSB] = i_rd_data;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_shift <= '0;
    end else if (state == mps_pkg::ST_IDLE && cs_fall) begin
      tx_shift <= tx_word;
    end else if (in_frame && sck_fall) begin
      tx_shift <= {tx_shift[mps_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  assign o_dout = tx_shift[mps_pkg::FRAME_BITS-1];

  // Output enable follows the synchronised select so it drops in the same
  // cycle the first bit is loaded and lifts as the frame closes.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dout_oe_n <= 1'b1;
    end else if (state == mps_pkg::ST_IDLE && cs_fall) begin
      o_dout_oe_n <= 1'b0;
    end else if (cs_rise || state != mps_pkg::ST_FRAME) begin
      o_dout_oe_n <= 1'b1;
    end
  end

  // ****************************************************************
  // Idle gap watch
  // ****************************************************************
  // A too-short gap is only reported; the frame is still served.
  logic [mps_pkg::GAP_W-1:0] gap_cnt;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_cnt <= mps_pkg::WAIT_CNT;
    end else if (cs_rise) begin
      gap_cnt <= '0;
    end else if (state == mps_pkg::ST_IDLE && gap_cnt != mps_pkg::WAIT_CNT) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gap_short <= 1'b0;
    end else begin
      o_gap_short <= (state == mps_pkg::ST_IDLE) && cs_fall
                     && (gap_cnt != mps_pkg::WAIT_CNT);
    end
  end

  // ****************************************************************
  // Write queue
  // ****************************************************************
  mps_fifo #(
    .WIDTH(mps_pkg::WR_WIDTH),
    .DEPTH(mps_pkg::WR_DEPTH)
  ) u_wr_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .s_in(fill_if),
    .s_out(drain_if)
  );

  assign drain_if.ready = i_wr_ready;
  assign o_wr_valid = drain_if.valid;
  assign o_wr_addr = drain_if.data[mps_pkg::WR_WIDTH-1:8];
  assign o_wr_data = drain_if.data[7:0];

endmodule

// file: logic/mps_strm_if.sv
// Valid/ready stream carrier between the port logic and its write queue.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mps_strm_if #(
  parameter int WIDTH = 14
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface

// file: sim/mps_master_model.sv
// Behavioural microcontroller acting as master of the serial link.
// Assumes the bench calls xfer; all pins change on falling reference edges.
`timescale 1ns/1ps
module mps_master_model (
  input wire logic i_ref_clk, // Timing reference.
  input wire logic i_dout, // Pin level from the slave.
  output logic o_cs_n, // Chip select.
  output logic o_sck, // Serial clock.
  output logic o_din // Serial data.
);
  initial begin
    o_cs_n = 1'h1;
    o_sck = 1'h0;
    o_din = 1'h0;
  end

  task automatic half(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // Eight reference cycles per pulse keep the link at 2.5 MHz.
  task automatic xfer(input logic [15:0] tx, input int pulses, input int gap,
      output logic [15:0] rx);
    rx = 16'h0000;
    half(1);
    o_cs_n = 1'h0;
    half(8);
    for (int i = 0; i < pulses; i++) begin
      o_din = tx[15 - (i % 16)];
      half(4);
      o_sck = 1'h1;
      rx = {rx[14:0], i_dout};
      half(4);
      o_sck = 1'h0;
    end
    half(4);
    o_cs_n = 1'h1;
    o_din = 1'h0;
    half(gap);
  endtask

  // Toggles clock and data while select stays high; the slave must ignore it.
  task automatic idle_noise(input int n);
    repeat (n) begin
      half(1);
      o_sck = ~o_sck;
      o_din = ~o_din;
    end
  endtask
endmodule

// file: sim/mps_spi_checker.sv
// Pin-level checks for the serial slave port.
// Assumes it is bound to mps_spi_slave and sees its ports only.
`timescale 1ns/1ps
module mps_spi_checker (
  input wire logic i_ref_clk, // Clock.
  input wire logic i_rst_n, // Reset.
  input wire logic i_cs_n, // Select.
  input wire logic i_sck, // Serial clock.
  input wire logic i_wr_ready, // Queue take.
  input wire logic o_dout, // Data out.
  input wire logic o_dout_oe_n, // Out enable.
  input wire logic o_wr_valid, // Queue offer.
  input wire logic [5:0] o_wr_addr, // Queue head.
  input wire logic o_frame_fault, // Fault flag.
  input wire logic o_gap_short // Gap pulse.
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_rst_quiet: assert property ($rose(i_rst_n) |-> o_dout_oe_n && !o_wr_valid &&
    !o_frame_fault) else $error("outputs not quiet after reset");
  chk_oe_idle: assert property (i_cs_n[*7] |-> o_dout_oe_n)
    else $error("data out driven while deselected");
  chk_oe_on: assert property ($fell(i_cs_n) ##1 !i_cs_n[*6] |-> !o_dout_oe_n)
    else $error("data out not driven in frame");
  chk_msb_zero: assert property ($fell(o_dout_oe_n) |-> !o_dout)
    else $error("first output bit not zero");
  chk_dout_hold: assert property ($fell(i_sck) && !i_cs_n |=> $stable(o_dout)[*2])
    else $error("data out moved too early");
  chk_fault_close: assert property ($changed(o_frame_fault) |-> $past(i_cs_n, 4))
    else $error("fault flag moved inside a frame");
  chk_wr_enter: assert property ($rose(o_wr_valid) |-> $past(i_cs_n, 3))
    else $error("write queued inside a frame");
  chk_head_hold: assert property (o_wr_valid && !i_wr_ready |=>
    o_wr_valid && $stable(o_wr_addr)) else $error("queue head lost");
  chk_gap_pulse: assert property (o_gap_short |=> !o_gap_short)
    else $error("gap pulse too long");

  cover property ($fell(o_dout_oe_n));
  cover property ($rose(o_frame_fault));
  cover property ($rose(o_wr_valid));
  cover property (o_gap_short);
endmodule

bind mps_spi_slave mps_spi_checker i_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .i_wr_ready(i_wr_ready), .o_dout(o_dout),
  .o_dout_oe_n(o_dout_oe_n), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
  .o_frame_fault(o_frame_fault), .o_gap_short(o_gap_short));

// file: sim/tb_mps_spi_slave.sv
// Self-checking bench for the serial slave port and its write queue.
// Assumes the master model frames every transfer; the bench plays the core.
`timescale 1ns/1ps
module tb_mps_spi_slave;
  logic clk;
  logic rst_n;
  logic wr_ready;
  logic [7:0] rd_data;
  logic cs_n, sck, din, dout, oe_n, wr_valid, fault, gap_short;
  logic [5:0] rd_addr;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [15:0] rx;
  wire pin;
  int bad_count;
  int checked;
  int gaps = 0;

  assign pin = oe_n ? 1'hz : dout;

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  mps_master_model i_m (.i_ref_clk(clk), .i_dout(pin), .o_cs_n(cs_n), .o_sck(sck),
    .o_din(din));
  mps_spi_slave i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck),
    .i_din(din), .o_dout(dout), .o_dout_oe_n(oe_n), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_frame_fault(fault),
    .o_gap_short(gap_short));

  // The core answers a read with a byte made from the address, so replies are traceable.
  always @(negedge clk) rd_data <= {2'h2, rd_addr};
  always @(posedge clk) if (gap_short === 1'h1) gaps <= gaps + 1;

  function automatic logic [15:0] reply(input logic f, input logic [5:0] a);
    return {1'h0, f, 5'h00, 1'h1, 2'h2, a};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [5:0] a, input int n);
    i_m.xfer({mps_pkg::RW_READ, a, 8'h5a}, n, 110, rx);
  endtask

  task automatic take(input logic [5:0] a, input logic [7:0] d);
    check("wr_valid", 16'(wr_valid), 16'h0001);
    check("wr_head", {2'h0, wr_addr, wr_data}, {2'h0, a, d});
    wr_ready = 1'h1;
    @(negedge clk);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic sc_read;
    rd(6'h2a, 16);
    check("reply", rx, reply(1'h0, 6'h00));
    rd(6'h15, 16);
    check("reply", rx, reply(1'h0, 6'h2a));
    check("rd_addr", 16'(rd_addr), 16'h0015);
    check("pin", {15'h0000, pin}, {15'h0000, 1'hz});
  endtask

  task automatic sc_idle_noise;
    i_m.idle_noise(20);
    check("pin", {15'h0000, pin}, {15'h0000, 1'hz});
    rd(6'h07, 16);
    check("reply", rx, reply(1'h0, 6'h15));
    check("fault", 16'(fault), 16'h0000);
  endtask

  task automatic sc_bad_count;
    rd(6'h33, 15);
    check("reply", rx, reply(1'h0, 6'h07) >> 1);
    check("fault", 16'(fault), 16'h0001);
    check("rd_addr", 16'(rd_addr), 16'h0007);
    i_m.xfer({mps_pkg::RW_WRITE, 6'h3f, 8'ha5}, 17, 110, rx);
    check("wr_valid", 16'(wr_valid), 16'h0000);
    rd(6'h08, 16);
    check("reply", rx, reply(1'h1, 6'h07));
    check("fault", 16'(fault), 16'h0000);
  endtask

  task automatic sc_codes;
    for (int c = 3; c >= 0; c--) begin
      i_m.xfer({2'(c), 6'(6'h10 + c), 8'h3c}, 16, 110, rx);
      check("wr_valid", 16'(wr_valid), 16'(c == 1));
      check("rd_addr", 16'(rd_addr), (c == 0) ? 16'h0010 : 16'h0008);
      check("fault", 16'(fault), 16'h0000);
      if (c == 1) begin
        take(6'h11, 8'h3c);
        wr_ready = 1'h0;
      end
    end
  endtask

  task automatic sc_fill;
    for (int i = 0; i < 17; i++) begin
      i_m.xfer({mps_pkg::RW_WRITE, 6'(i), 8'(8'h80 + i)}, 16, 110, rx);
      check("fault", 16'(fault), 16'(i == 16));
    end
    for (int i = 0; i < 16; i++) begin
      take(6'(i), 8'(8'h80 + i));
    end
    wr_ready = 1'h0;
    check("wr_valid", 16'(wr_valid), 16'h0000);
  endtask

  task automatic sc_gap;
    int g0;
    g0 = gaps;
    i_m.xfer({mps_pkg::RW_READ, 6'h21, 8'h00}, 16, 20, rx);
    rd(6'h22, 16);
    check("reply", rx, reply(1'h0, 6'h21));
    check("gaps", 16'(gaps - g0), 16'h0001);
  endtask

  initial begin
    rst_n = 1'h0;
    wr_ready = 1'h0;
    bad_count = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    repeat (5) @(negedge clk);
    sc_read();
    sc_idle_noise();
    sc_bad_count();
    sc_codes();
    sc_fill();
    sc_gap();
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
